// *** rtl/occ_regs.vh ***
// Purpose: constants for the memory command control block
// Assumes: included by bare name
// Notes: definitions only
`ifndef OCC_REGS_VH
`define OCC_REGS_VH
`define OCC_ADDR_W 16
`define OCC_ADDR_CTRL 16'h400a
`define OCC_ADDR_STATUS 16'h400b
`define OCC_ADDR_KEY 16'h400c
`define OCC_ADDR_LOCKS 16'h400d
`define OCC_KEY_CODE 16'h9716
`define OCC_BIT_PROG 15
`define OCC_BIT_MEM 13
`define OCC_BIT_FINAL 11
`define OCC_BIT_VERIFY 10
`define OCC_BIT_WRITE 9
`define OCC_BIT_READ 8
`define OCC_LVL_HI 7
`define OCC_LVL_LO 6
`define OCC_BIT_BULK 5
`define OCC_PAGE_HI 1
`define OCC_PAGE_LO 0
`define OCC_BIT_DONE 5
`define OCC_BIT_ERR 4
`define OCC_CTRL_RESET 16'h2000
`define OCC_CTRL_MASK 16'hafe3
`define OCC_OP_TIME_NS 200
`define OCC_CLK_NS 10
`define OCC_OP_CYCLES ((`OCC_OP_TIME_NS + `OCC_CLK_NS - 1) / `OCC_CLK_NS)
`define OCC_PAGES 4
`endif

// *** rtl/occ_page_lock.v ***
// Purpose: per-page programmed and lock state of the one-time memory
// Assumes: single clock, synchronous active-low reset
// Notes: pages 0 and 1 come up programmed and locked
`timescale 1ns/1ps
`default_nettype none
`include "occ_regs.vh"
module occ_page_lock (
  input wire clk,
  input wire rst_b,
  input wire [3:0] prog_set,
  input wire final_set,
  output wire [3:0] programmed,
  output wire [3:0] locked
);
  reg [3:0] prog_reg;
  reg final_reg;
  genvar i;
  generate
    for (i = 0; i < `OCC_PAGES; i = i + 1) begin : g_page
      always @(posedge clk) begin
        if (!rst_b) begin
          prog_reg[i] <= (i < 2) ? 1'b1 : 1'b0;
        end else if (prog_set[i]) begin
          prog_reg[i] <= 1'b1;
        end
      end
      // lock 2 and 3 after finalise
      assign locked[i] = (i < 2) ? 1'b1 : final_reg;
    end
  endgenerate
  always @(posedge clk) begin
    if (!rst_b) begin
      final_reg <= 1'b0;
    end else if (final_set) begin
      final_reg <= 1'b1;
    end
  end
  assign programmed = prog_reg;
endmodule // occ_page_lock
`default_nettype wire

// *** rtl/occ_cmd_ctrl.v ***
// Purpose: command control for the one-time configuration memory
// Assumes: plain register port, read data one cycle after the read strobe
// Notes: memory array is modelled by per-page state; verify compares a compare input
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "occ_regs.vh"
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Writing one to bit 11 starts finalise.
// - After finalise, writes to pages 2 and 3 are refused.
// - Pages 0 and 1 are locked from reset, never rewritable.
// - Each page programs at most once.
// - Finalise only on internal memory; external select gives error.
// - Finalise targets page 2, locking pages 2 and 3.
// - Finalise leaves the window copy of the lock bit alone.
// - Control at 400Ah; key register must hold code before changes.
// - Bit 15 enters program state, held until reset.
// - Bit 13 selects target memory, reset value one.
// - Bits 10, 9, 8 start verify, write, read.
// - Bits 7:6 set margin level.
// - Bit 5 selects single page or all pages.
// - Bits 1:0 pick page; external mapping differs, 11 reserved.
// - Commands accepted only in program state, entered from off.
// - Error on external read fail, verify mismatch, finalised write.
// - Done flag set per command, cleared by writing one.
module occ_cmd_ctrl (
  input wire clk,
  input wire rst_b,
  input wire [15:0] addr,
  input wire [15:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [15:0] rdata,
  input wire state_off,
  input wire ext_read_fail,
  input wire verify_match,
  input wire window_lock_bit,
  output reg program_state,
  output reg busy,
  output reg [1:0] read_margin_level,
  output reg mem_internal,
  output reg [2:0] op_page,
  output reg op_read,
  output reg op_write,
  output reg op_verify,
  output reg op_final,
  output reg command_done_flag,
  output reg command_error_flag
);
  localparam ST_IDLE = 2'd0;
  localparam ST_RUN = 2'd1;
  localparam ST_DONE = 2'd2;
  localparam [31:0] OP_CYC_FULL = `OCC_OP_CYCLES;
  localparam [7:0] OP_CYC = OP_CYC_FULL[7:0];

  reg [15:0] ctrl_reg;
  reg [15:0] ctrl_next;
  reg key_ok_reg;
  reg [1:0] state_reg;
  reg [7:0] cnt_reg;
  reg [2:0] last_page_reg;
  reg err_pend_reg;
  reg [3:0] prog_set;
  reg final_set;
  reg done_set;
  reg err_set;
  reg launch;
  reg launch_err;
  wire [3:0] programmed;
  wire [3:0] locked;
  wire wr_ctrl;
  wire cmd_any;
  wire [2:0] first_page;
  wire [2:0] last_page;
  wire verify_bad;

  occ_page_lock occ_page_lock_inst (
    .clk(clk),
    .rst_b(rst_b),
    .prog_set(prog_set),
    .final_set(final_set),
    .programmed(programmed),
    .locked(locked)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control address decode
  assign wr_ctrl = wr_stb && (addr == `OCC_ADDR_CTRL);
  assign cmd_any = wdata[`OCC_BIT_FINAL] | wdata[`OCC_BIT_VERIFY] |
                   wdata[`OCC_BIT_WRITE] | wdata[`OCC_BIT_READ];

  assign first_page = wdata[`OCC_BIT_BULK] ?
                      (wdata[`OCC_BIT_MEM] ? 3'd0 : 3'd2) :
                      (wdata[`OCC_BIT_MEM] ? {1'b0, wdata[1:0]} :
                       (3'd2 + {1'b0, wdata[1:0]}));
  assign last_page = wdata[`OCC_BIT_BULK] ?
                     (wdata[`OCC_BIT_MEM] ? 3'd3 : 3'd4) : first_page;

  // window copy of lock bit feeds verify only, never written here
  assign verify_bad = !verify_match ||
                      (locked[3] && !window_lock_bit && op_page == 3'd2);

  // Key register: a wrong code relocks
  always @(posedge clk) begin
    if (!rst_b) begin
      key_ok_reg <= 1'b0;
    end else if (wr_stb && addr == `OCC_ADDR_KEY) begin
      key_ok_reg <= (wdata == `OCC_KEY_CODE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Launch decision
  always @* begin
    ctrl_next = ctrl_reg;
    launch = 1'b0;
    launch_err = 1'b0;
    if (wr_ctrl && key_ok_reg && state_reg == ST_IDLE) begin
      // Bit 15 mirrors program_state; trigger bits kept only on launch
      ctrl_next = (wdata & `OCC_CTRL_MASK & 16'h70ff) | (ctrl_reg & 16'h8000);
      if (cmd_any && program_state) begin
        launch = 1'b1;
        ctrl_next[`OCC_BIT_FINAL:`OCC_BIT_READ] = wdata[`OCC_BIT_FINAL:`OCC_BIT_READ];
        if (wdata[`OCC_BIT_FINAL] &&
            (!wdata[`OCC_BIT_MEM] || wdata[`OCC_BIT_BULK] || wdata[1:0] != 2'b10)) begin
          launch_err = 1'b1;
        end
        // External write or verify unsupported; reserved external page
        if (!wdata[`OCC_BIT_MEM] && (wdata[`OCC_BIT_WRITE] || wdata[`OCC_BIT_VERIFY] ||
            (!wdata[`OCC_BIT_BULK] && wdata[1:0] == 2'b11))) begin
          launch_err = 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always @(posedge clk) begin
    if (!rst_b) begin
      ctrl_reg <= `OCC_CTRL_RESET;
      program_state <= 1'b0;
      state_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
      busy <= 1'b0;
      read_margin_level <= 2'b00;
      mem_internal <= 1'b1;
      op_page <= 3'd0;
      last_page_reg <= 3'd0;
      op_read <= 1'b0;
      op_write <= 1'b0;
      op_verify <= 1'b0;
      op_final <= 1'b0;
      err_pend_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      if (wr_ctrl && key_ok_reg && wdata[`OCC_BIT_PROG] && state_off) begin
        program_state <= 1'b1;
        ctrl_reg[`OCC_BIT_PROG] <= 1'b1;
      end
      case (state_reg)
        ST_IDLE: begin
          if (launch) begin
            state_reg <= ST_RUN;
            busy <= 1'b1;
            cnt_reg <= OP_CYC;
            mem_internal <= wdata[`OCC_BIT_MEM];
            read_margin_level <= wdata[`OCC_LVL_HI:`OCC_LVL_LO];
            op_page <= first_page;
            last_page_reg <= last_page;
            op_final <= wdata[`OCC_BIT_FINAL];
            op_verify <= wdata[`OCC_BIT_VERIFY];
            op_write <= wdata[`OCC_BIT_WRITE];
            op_read <= wdata[`OCC_BIT_READ];
            err_pend_reg <= launch_err;
          end
        end
        ST_RUN: begin
          if (cnt_reg == 8'h01) begin
            if ((op_read && !mem_internal && ext_read_fail) ||
                (op_verify && verify_bad) ||
                (op_write && op_page < 3'd4 &&
                 (locked[op_page[1:0]] || programmed[op_page[1:0]]))) begin
              err_pend_reg <= 1'b1;
            end
            if (op_page == last_page_reg || op_final) begin
              state_reg <= ST_DONE;
            end else begin
              op_page <= op_page + 3'd1;
              cnt_reg <= OP_CYC;
            end
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        ST_DONE: begin
          state_reg <= ST_IDLE;
          busy <= 1'b0;
          err_pend_reg <= 1'b0;
          op_read <= 1'b0;
          op_write <= 1'b0;
          op_verify <= 1'b0;
          op_final <= 1'b0;
          ctrl_reg[11:8] <= 4'h0;
        end
        default: begin
          state_reg <= ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page state updates
  always @* begin
    prog_set = 4'h0;
    final_set = 1'b0;
    if (state_reg == ST_RUN && cnt_reg == 8'h01 && !err_pend_reg && mem_internal) begin
      if (op_write && op_page < 3'd4 &&
          !locked[op_page[1:0]] && !programmed[op_page[1:0]]) begin
        prog_set[op_page[1:0]] = 1'b1;
      end
      // page 2 lock covers 2 and 3
      if (op_final) begin
        final_set = 1'b1;
      end
    end
  end

  always @* begin
    done_set = (state_reg == ST_DONE);
    err_set = (state_reg == ST_DONE) && err_pend_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: set wins over write-one clear
  always @(posedge clk) begin
    if (!rst_b) begin
      command_done_flag <= 1'b0;
      command_error_flag <= 1'b0;
    end else begin
      if (done_set) begin
        command_done_flag <= 1'b1;
      end else if (wr_stb && addr == `OCC_ADDR_STATUS && wdata[`OCC_BIT_DONE]) begin
        command_done_flag <= 1'b0;
      end
      if (err_set) begin
        command_error_flag <= 1'b1;
      end else if (wr_stb && addr == `OCC_ADDR_STATUS && wdata[`OCC_BIT_ERR]) begin
        command_error_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port; unmapped addresses read zero
  always @(posedge clk) begin
    if (!rst_b) begin
      rdata <= 16'h0000;
    end else if (rd_stb) begin
      case (addr)
        `OCC_ADDR_CTRL: rdata <= ctrl_reg;
        `OCC_ADDR_STATUS: rdata <= {10'h000, command_done_flag, command_error_flag,
                                    3'h0, busy};
        `OCC_ADDR_KEY: rdata <= {15'h0000, key_ok_reg};
        `OCC_ADDR_LOCKS: rdata <= {8'h00, locked, programmed};
        default: rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end
endmodule // occ_cmd_ctrl
`default_nettype wire

// *** verification/occ_cmd_checker.sv ***
// Purpose: port assertions for occ_cmd_ctrl
// Assumes: one clock, synchronous active-low reset
// Notes: bound to the control block below
`timescale 1ns/1ps
`default_nettype none
module occ_cmd_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] wdata,
  input wire logic program_state,
  input wire logic busy,
  input wire logic [1:0] read_margin_level,
  input wire logic mem_internal,
  input wire logic [2:0] op_page,
  input wire logic op_read,
  input wire logic op_write,
  input wire logic op_verify,
  input wire logic op_final
  ,
  input wire logic command_done_flag,
  input wire logic command_error_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic any_op = op_read | op_write | op_verify | op_final;
  sequence s_fin_start;
    $rose(busy) && op_final;
  endsequence
  sequence s_fin_end;
    !busy && command_done_flag;
  endsequence
  prog_hold_a: assert property (program_state |=> program_state)
    else $error("program state dropped");
  done_end_a: assert property ($fell(busy) |-> command_done_flag)
    else $error("no done flag at end");
  op_one_a: assert property (busy |-> $onehot({op_read, op_write, op_verify, op_final}))
    else $error("not one operation");
  op_idle_a: assert property (!busy |-> !any_op)
    else $error("operation while idle");
  cmd_prog_a: assert property ($rose(busy) |-> program_state)
    else $error("command outside program state");
  mem_sel_a: assert property ($rose(busy) |-> mem_internal == $past(wdata[13]))
    else $error("memory select wrong");
  margin_sel_a: assert property ($rose(busy) |-> read_margin_level == $past(wdata[7:6]))
    else $error("margin level wrong");
  page_map_a: assert property ($rose(busy) && !$past(wdata[5]) && (mem_internal ||
    (op_read && $past(wdata[1:0]) != 2'b11)) |-> op_page == {1'b0, $past(wdata[1:0])}
    + {1'b0, !mem_internal, 1'b0}) else $error("page mapping wrong");
  final_time_a: assert property (s_fin_start |-> ##21 s_fin_end)
    else $error("finalise timing wrong");
  final_ext_a: assert property (s_fin_start and !mem_internal |-> ##21 command_error_flag)
    else $error("external finalise not refused");
endmodule // occ_cmd_checker
bind occ_cmd_ctrl occ_cmd_checker occ_cmd_checker_inst (.clk, .rst_b, .wdata, .program_state,
  .busy, .read_margin_level, .mem_internal, .op_page, .op_read, .op_write, .op_verify,
  .op_final, .command_done_flag, .command_error_flag);
`default_nettype wire

// *** verification/occ_host.sv ***
// Purpose: host side of the register port
// Assumes: slave never waits, read data one cycle on
// Notes: drives only right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module occ_host (
  input wire logic clk,
  input wire logic [15:0] rdata,
  output logic [15:0] addr,
  output logic [15:0] wdata,
  output logic wr_stb,
  output logic rd_stb
);
  initial begin
    addr = 16'h0000;
    wdata = 16'h0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  task wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask
endmodule // occ_host
`default_nettype wire

// *** verification/occ_cmd_ctrl_bench.sv ***
// Purpose: self-checking bench for occ_cmd_ctrl
// Assumes: host model owns the register port
// Notes: command bits 16..19 set fail, mismatch, window bit, busy rewrite
`timescale 1ns/1ps
`default_nettype none
`include "occ_regs.vh"
module occ_cmd_ctrl_bench;
  logic clk, rst_b, state_off, ext_read_fail, verify_match, window_lock_bit;
  wire logic [15:0] addr, wdata, rdata;
  wire logic wr_stb, rd_stb, program_state, busy, mem_internal, op_read, op_write;
  wire logic op_verify, op_final, command_done_flag, command_error_flag;
  wire logic [1:0] read_margin_level;
  wire logic [2:0] op_page;
  int num_errors, n_tests, seed, prog_m, lock_m;
  logic [15:0] d;
  int cmds[$] = '{20'h0_2101, 20'h0_2102, 20'h0_2120, 20'h0_0120, 20'h0_0101, 20'h0_0102,
    20'h1_0100, 20'h0_0103, 20'h0_0202, 20'h0_2200, 20'h8_2202, 20'h0_2202, 20'h2_2482,
    20'h0_2400, 20'h0_2440, 20'h0_2480, 20'h0_24c0, 20'h0_0802, 20'h0_2803, 20'h0_2822,
    20'h0_2802, 20'h0_2482, 20'h4_2482, 20'h0_2203, 20'h0_2220, 20'h0_24a0};
  occ_host host_inst (.clk, .rdata, .addr, .wdata, .wr_stb, .rd_stb);
  occ_cmd_ctrl occ_cmd_ctrl_inst (.clk, .rst_b, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
    .state_off, .ext_read_fail, .verify_match, .window_lock_bit, .program_state, .busy,
    .read_margin_level, .mem_internal, .op_page, .op_read, .op_write, .op_verify, .op_final,
    .command_done_flag, .command_error_flag);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task complete_run;
    if (num_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task check(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  endtask
  task wait_busy(input logic lv);
    int n;
    n = 0;
    while (busy !== lv && n < 300) begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 300) begin
      num_errors++;
      $display("Error %0t: busy wait ran out", $time);
      complete_run;
    end
  endtask
  // Expected error; updates page state
  function int model(int c);
    int pg, m, b, e;
    pg = c[1:0];
    m = c[13];
    b = c[5];
    e = 0;
    if (c[8]) e = !m && (c[16] || (pg == 3 && !b));
    if (c[9]) begin
      if (!m || b || ((prog_m | lock_m) >> pg) % 2) e = 1;
      else prog_m = prog_m | (1 << pg);
    end
    if (c[10]) e = !m || c[17] || (lock_m[2] && !c[18] && (b || pg == 2));
    if (c[11]) begin
      if (!m || b || pg != 2) e = 1;
      else lock_m = lock_m | 4'hc;
    end
    return e;
  endfunction
  task run(input int c);
    int e;
    @(posedge clk);
    ext_read_fail <= c[16];
    verify_match <= !c[17];
    window_lock_bit <= c[18];
    e = model(c);
    host_inst.wr(`OCC_ADDR_STATUS, 16'h0030);
    host_inst.rd(`OCC_ADDR_STATUS, d);
    check(d, 16'h0000);
    host_inst.wr(`OCC_ADDR_CTRL, c[15:0]);
    if (c[19]) host_inst.wr(`OCC_ADDR_CTRL, 16'h2203);
    wait_busy(1'b1);
    wait_busy(1'b0);
    check(command_done_flag, 1'b1);
    check(command_error_flag, e[0]);
    host_inst.rd(`OCC_ADDR_LOCKS, d);
    check(d, 16'((lock_m << 4) | prog_m));
    host_inst.rd(`OCC_ADDR_CTRL, d);
    check(d, (c[15:0] & 16'ha0e3) | 16'h8000);
  endtask
  initial begin
    seed = 32'hdfe5_6963;
    num_errors = 0;
    n_tests = 0;
    prog_m = 3;
    lock_m = 3;
    rst_b = 1'b0;
    state_off = 1'b0;
    ext_read_fail = 1'b0;
    verify_match = 1'b1;
    window_lock_bit = 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    check(mem_internal, 1'b1);
    host_inst.rd(`OCC_ADDR_CTRL, d);
    check(d, 16'h2000);
    host_inst.rd(`OCC_ADDR_LOCKS, d);
    check(d, 16'h0033);
    host_inst.rd(16'h4010, d);
    check(d, 16'h0000);
    state_off <= 1'b1;
    host_inst.wr(`OCC_ADDR_CTRL, 16'h8000);
    host_inst.wr(`OCC_ADDR_KEY, `OCC_KEY_CODE);
    check(program_state, 1'b0);
    state_off <= 1'b0;
    host_inst.wr(`OCC_ADDR_CTRL, 16'h8000);
    host_inst.wr(`OCC_ADDR_CTRL, 16'h2202);
    @(posedge clk);
    state_off <= 1'b1;
    #1 check(program_state, 1'b0);
    check(busy, 1'b0);
    host_inst.rd(`OCC_ADDR_CTRL, d);
    check(d, 16'h2002);
    host_inst.wr(`OCC_ADDR_CTRL, 16'h8000);
    state_off <= 1'b0;
    host_inst.wr(`OCC_ADDR_CTRL, 16'h0000);
    host_inst.wr(16'h4010, 16'($random(seed)));
    host_inst.rd(`OCC_ADDR_CTRL, d);
    check(d, 16'h8000);
    check(program_state, 1'b1);
    foreach (cmds[i]) run(cmds[i]);
    // Odd value can never be the key
    host_inst.wr(`OCC_ADDR_KEY, 16'($random(seed)) | 16'h0001);
    host_inst.wr(`OCC_ADDR_CTRL, 16'h2102);
    @(posedge clk);
    #1 check(busy, 1'b0);
    complete_run;
  end
endmodule // occ_cmd_ctrl_bench
`default_nettype wire
